// [rtl/adcsr_pkg.sv]
// Behaviour
// - Status word is sixteen bits, read only
// - Status bits clear at power-up
// - Status bit 15 always reads zero
// - Bit 14 shows conversion or calibration busy
// - Bits 13..10 mirror input and channel selects
// - Bits 9..8 mirror power configuration bits
// - Bits 7..6 read one in status
// - Bit 5 interface mode, cleared each read
// - Bit 3 mirrors calibration kind select
// - Bit 0 reads one while calibrating
// - Bits 2..1 mirror calibration group select
// - Ten calibration registers, host and calibration writable
// - Group code picks gain, offset, DAC set
// - Same addressing for reads and writes
// - Pointer resets on control write or completion
// - Reset pointer addresses gain, offset-only excepted
// - Pointer advances after each group access
// - Abandoned sequence reset by next control write
// - Calibration reads carry two leading zeros
// - Calibration word is zeros plus 14 bits
// - Start-calibration bit clears when calibration finishes
package adcsr_pkg;
    localparam int WORD_W = 16;
    localparam int CAL_W = 14;
    localparam int CAL_NUM = 10;
    localparam int IDX_W = 4;
    localparam int CNT_W = 5;
    // Frame destination code in the top two bits of a written word
    localparam logic [1:0] DEST_NONE = 2'h0;
    localparam logic [1:0] DEST_CTRL = 2'h1;
    localparam logic [1:0] DEST_CAL = 2'h2;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 14;
    // Control and status field positions
    localparam int BIT_ZERO = 15;
    localparam int BIT_BUSY = 14;
    localparam int CHAN_HI = 13;
    localparam int CHAN_LO = 10;
    localparam int PWR_HI = 9;
    localparam int PWR_LO = 8;
    localparam int RDT_HI = 7;
    localparam int RDT_LO = 6;
    localparam int BIT_MODE = 5;
    localparam int BIT_DONTCARE = 4;
    localparam int BIT_CALKIND = 3;
    localparam int GRP_HI = 2;
    localparam int GRP_LO = 1;
    localparam int BIT_CALSTART = 0;
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    // Read targets
    localparam logic [1:0] RDT_RESULT = 2'h0;
    localparam logic [1:0] RDT_CAL = 2'h2;
    localparam logic [1:0] RDT_STATUS = 2'h3;
    // Calibration groups
    localparam logic [1:0] GRP_ALL = 2'h0;
    localparam logic [1:0] GRP_GAIN_OFS = 2'h1;
    localparam logic [1:0] GRP_OFS = 2'h2;
    localparam logic [1:0] GRP_GAIN = 2'h3;
    // Register indexes
    localparam logic [3:0] IDX_GAIN = 4'h0;
    localparam logic [3:0] IDX_OFS = 4'h1;
    localparam logic [3:0] IDX_DAC_LAST = 4'h9;
    localparam logic [13:0] CAL_RESET = 14'h0000;
    localparam logic [4:0] FRAME_BITS = 5'h10;
endpackage : adcsr_pkg

// [rtl/adcsr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module adcsr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic sclk,
    input wire logic syncN,
    input wire logic serIn,
    output logic serOut,
    output logic serOutEn,
    // Converter engine
    input wire logic convBusy,
    input wire logic [adcsr_pkg::WORD_W-1:0] convResult,
    input wire logic calDone,
    input wire logic calUpdValid,
    input wire logic [adcsr_pkg::IDX_W-1:0] calUpdIndex,
    input wire logic [adcsr_pkg::CAL_W-1:0] calUpdData,
    // Settings to the engine
    output logic [13:0] ctrlOut,
    output logic calStartFlag,
    output logic [adcsr_pkg::WORD_W-1:0] statusWord
);
    import adcsr_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [IDX_W-1:0] firstIdx(input logic [1:0] grp);
        firstIdx = (grp == GRP_OFS) ? IDX_OFS : IDX_GAIN;
    endfunction : firstIdx

    function automatic logic [IDX_W-1:0] lastIdx(input logic [1:0] grp);
        unique case (grp)
            GRP_ALL: lastIdx = IDX_DAC_LAST;
            GRP_GAIN_OFS: lastIdx = IDX_OFS;
            GRP_OFS: lastIdx = IDX_OFS;
            GRP_GAIN: lastIdx = IDX_GAIN;
        endcase
    endfunction : lastIdx

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinMeta_q;
    logic [2:0] pinSync_q;
    logic [2:0] pinPrev_q;
    wire [2:0] pinRaw = {serIn, syncN, sclk};

    // Reset to idle pin levels so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= 3'h2;
            pinSync_q <= 3'h2;
            pinPrev_q <= 3'h2;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    wire sclkRise = pinSync_q[0] && !pinPrev_q[0];
    wire sclkFall = !pinSync_q[0] && pinPrev_q[0];
    wire frameStart = !pinSync_q[1] && pinPrev_q[1];
    wire frameStop = pinSync_q[1] && !pinPrev_q[1];
    wire inFrame = !pinSync_q[1];
    wire dataIn = pinSync_q[2];

    // ------------------------------------------------------------
    // Frame shifters
    // ------------------------------------------------------------
    logic [WORD_W-1:0] rxShift_q;
    logic [WORD_W-1:0] rxShift_d;
    logic [WORD_W-1:0] txShift_q;
    logic [WORD_W-1:0] txShift_d;
    logic [CNT_W-1:0] bitCnt_q;
    logic [CNT_W-1:0] bitCnt_d;
    logic readWasCal_q;
    logic serOut_q;
    logic serOut_d;

    logic [13:0] ctrl_q;
    logic [13:0] ctrl_d;
    logic calStart_q;
    logic calStart_d;
    logic [IDX_W-1:0] ptr_q;
    logic [IDX_W-1:0] ptr_d;
    logic [CAL_W-1:0] calRegs_q [CAL_NUM];

    wire [1:0] readTarget = ctrl_q[RDT_HI:RDT_LO];
    wire [1:0] calGroup = ctrl_q[GRP_HI:GRP_LO];
    wire fullWord = (bitCnt_q == FRAME_BITS);
    wire frameDone = frameStop && fullWord;
    wire [1:0] rxDest = rxShift_q[DEST_HI:DEST_LO];
    wire ctrlWrite = frameDone && (rxDest == DEST_CTRL);
    wire calWrite = frameDone && (rxDest == DEST_CAL);
    wire calAccess = calWrite || (frameDone && readWasCal_q);
    wire [IDX_W-1:0] ptrFirst = firstIdx(calGroup);
    wire [IDX_W-1:0] ptrLast = lastIdx(calGroup);
    wire [CAL_W-1:0] calWord = calRegs_q[ptr_q];

    // ------------------------------------------------------------
    // Status word and read selection
    // ------------------------------------------------------------
    wire busyBit = convBusy || calStart_q;
    assign statusWord = {1'b0, busyBit, ctrl_q[CHAN_HI:PWR_LO], readTarget,
        ctrl_q[BIT_MODE], 1'b0, ctrl_q[BIT_CALKIND], calGroup, calStart_q};
    wire [WORD_W-1:0] calRead = {2'b00, calWord};
    wire [WORD_W-1:0] readWord = (readTarget == RDT_STATUS) ? statusWord :
        (readTarget == RDT_CAL) ? calRead : convResult;

    always_comb begin
        rxShift_d = rxShift_q;
        txShift_d = txShift_q;
        bitCnt_d = bitCnt_q;
        serOut_d = serOut_q;
        if (frameStart) begin
            txShift_d = readWord;
            bitCnt_d = '0;
            serOut_d = readWord[WORD_W-1];
        end else if (inFrame) begin
            if (sclkRise && !fullWord) begin
                rxShift_d = {rxShift_q[WORD_W-2:0], dataIn};
                bitCnt_d = bitCnt_q + 5'h01;
                txShift_d = {txShift_q[WORD_W-2:0], 1'b0};
            end
            if (sclkFall) begin
                serOut_d = txShift_q[WORD_W-1];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxShift_q <= '0;
            txShift_q <= '0;
            bitCnt_q <= '0;
            serOut_q <= 1'b0;
            readWasCal_q <= 1'b0;
        end else begin
            rxShift_q <= rxShift_d;
            txShift_q <= txShift_d;
            bitCnt_q <= bitCnt_d;
            serOut_q <= serOut_d;
            if (frameStart) begin
                readWasCal_q <= (readTarget == RDT_CAL);
            end
        end
    end

    assign serOut = serOut_q;
    assign serOutEn = inFrame;

    // ------------------------------------------------------------
    // Control register and calibration start
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        calStart_d = calStart_q;
        if (frameDone) begin
            ctrl_d[BIT_MODE] = 1'b0;
        end
        if (calDone) begin
            calStart_d = 1'b0;
        end
        if (ctrlWrite) begin
            ctrl_d = rxShift_q[13:0];
            ctrl_d[BIT_CALSTART] = 1'b0;
            if (rxShift_q[BIT_CALSTART]) begin
                calStart_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            calStart_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            calStart_q <= calStart_d;
        end
    end

    assign ctrlOut = ctrl_q;
    assign calStartFlag = calStart_q;

    // ------------------------------------------------------------
    // Calibration pointer
    // ------------------------------------------------------------
    wire [1:0] newGroup = rxShift_q[GRP_HI:GRP_LO];
    always_comb begin
        ptr_d = ptr_q;
        if (ctrlWrite) begin
            ptr_d = firstIdx(newGroup);
        end else if (calAccess) begin
            if (ptr_q == ptrLast) begin
                ptr_d = ptrFirst;
            end else begin
                ptr_d = ptr_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= IDX_GAIN;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // ------------------------------------------------------------
    // Calibration register storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CAL_NUM; gi++) begin : g_cal
            wire hostHit = calWrite && (ptr_q == IDX_W'(gi));
            wire engHit = calUpdValid && (calUpdIndex == IDX_W'(gi));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    calRegs_q[gi] <= CAL_RESET;
                end else if (engHit) begin
                    calRegs_q[gi] <= calUpdData;
                end else if (hostHit) begin
                    calRegs_q[gi] <= rxShift_q[CAL_W-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_ctrl_write;
        ctrlWrite;
    endsequence

    sequence s_cal_frame_load;
        frameStart && (readTarget == RDT_CAL);
    endsequence

    sequence s_status_frame_load;
        frameStart && (readTarget == RDT_STATUS);
    endsequence

    a_zero_msb: assert property (@(posedge clk) disable iff (!rst_n)
        statusWord[BIT_ZERO] == 1'b0) else $error("status msb not zero");

    a_status_tag: assert property (@(posedge clk) disable iff (!rst_n)
        s_status_frame_load |=> txShift_q[RDT_HI:RDT_LO] == 2'b11)
        else $error("status tag bits wrong");

    a_busy_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (convBusy && !calStart_q) |-> statusWord[BIT_BUSY]) else $error("busy not shown");

    a_cal_finish: assert property (@(posedge clk) disable iff (!rst_n)
        (calDone && !ctrlWrite) |=> !statusWord[BIT_CALSTART] && !calStartFlag)
        else $error("calibration flag not cleared");

    a_ptr_reset: assert property (@(posedge clk) disable iff (!rst_n)
        s_ctrl_write |=> ptr_q == firstIdx($past(newGroup))) else $error("pointer not reset");

    a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
        (calAccess && !ctrlWrite && ptr_q != ptrLast) |=> ptr_q == $past(ptr_q) + 4'h1)
        else $error("pointer did not advance");

    a_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (calAccess && !ctrlWrite && ptr_q == ptrLast) |=> ptr_q == $past(ptrFirst))
        else $error("pointer did not wrap");

    a_mode_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (frameDone && !ctrlWrite) |=> !statusWord[BIT_MODE]) else $error("mode bit kept");

    a_cal_lead: assert property (@(posedge clk) disable iff (!rst_n)
        s_cal_frame_load |=> txShift_q[WORD_W-1:WORD_W-2] == 2'b00)
        else $error("calibration read lacks zeros");

    a_chan_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrlWrite |=> $stable(statusWord[CHAN_HI:CHAN_LO])) else $error("channel bits moved");

    a_cal_store: assert property (@(posedge clk) disable iff (!rst_n)
        (calWrite && !calUpdValid) |=> calRegs_q[$past(ptr_q)] == $past(rxShift_q[CAL_W-1:0]))
        else $error("calibration write lost");

    a_status_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_status_frame_load |=> txShift_q == $past(statusWord))
        else $error("status word not loaded");

    a_cal_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_cal_frame_load |=> txShift_q == {2'b00, $past(calWord)})
        else $error("calibration word not loaded");

    a_first_bit: assert property (@(posedge clk) disable iff (!rst_n)
        frameStart |=> serOut == $past(readWord[WORD_W-1]))
        else $error("first bit not presented");

    a_chan_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_ctrl_write |=> statusWord[CHAN_HI:CHAN_LO] == $past(rxShift_q[CHAN_HI:CHAN_LO]))
        else $error("channel bits not shown");

    a_power_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_ctrl_write |=> statusWord[PWR_HI:PWR_LO] == $past(rxShift_q[PWR_HI:PWR_LO]))
        else $error("power bits not shown");

    a_mode_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_ctrl_write |=> statusWord[BIT_MODE] == $past(rxShift_q[BIT_MODE]))
        else $error("mode bit not shown");

    a_kind_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_ctrl_write |=> statusWord[BIT_CALKIND] == $past(rxShift_q[BIT_CALKIND]))
        else $error("calibration kind not shown");

    a_group_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_ctrl_write |=> statusWord[GRP_HI:GRP_LO] == $past(newGroup))
        else $error("calibration group not shown");

    a_cal_running: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && rxShift_q[BIT_CALSTART]) |=> statusWord[BIT_CALSTART] && calStartFlag)
        else $error("calibration run not shown");

    a_busy_cal: assert property (@(posedge clk) disable iff (!rst_n)
        calStartFlag |-> statusWord[BIT_BUSY])
        else $error("busy missing while calibrating");

    a_busy_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (!convBusy && !calStartFlag) |-> !statusWord[BIT_BUSY])
        else $error("busy shown while idle");

    a_ptr_range: assert property (@(posedge clk) disable iff (!rst_n)
        ptr_q <= IDX_DAC_LAST)
        else $error("pointer out of range");

    a_ofs_start: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && newGroup == GRP_OFS) |=> ptr_q == IDX_OFS)
        else $error("offset group not at offset");

    a_full_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (calAccess && !ctrlWrite && calGroup == GRP_ALL && ptr_q == IDX_DAC_LAST) |=>
        ptr_q == IDX_GAIN)
        else $error("full group did not wrap to gain");

    a_eng_update: assert property (@(posedge clk) disable iff (!rst_n)
        (calUpdValid && calUpdIndex <= IDX_DAC_LAST) |=>
        calRegs_q[$past(calUpdIndex)] == $past(calUpdData))
        else $error("engine update lost");

    a_ctrl_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (frameDone && !ctrlWrite) |=> $stable(ctrl_q[CHAN_HI:RDT_LO]))
        else $error("settings changed by a non-control frame");
endmodule : adcsr_regs
`default_nettype wire

// [tb/adcsr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module adcsr_host_model (
    // Serial pins
    output logic sclk,
    output logic syncN,
    output logic serIn,
    input wire logic serOut,
    input wire logic serOutEn
);
    initial begin
        sclk = 1'b0;
        syncN = 1'b1;
        serIn = 1'b0;
    end
    // ----------------------------------------
    // One 16-bit frame, MSB first
    // ----------------------------------------
    task automatic frame(input logic [15:0] wr, output logic [15:0] rd, output logic enOk);
        enOk = 1'b1;
        syncN <= 1'b0;
        #40;
        for (int i = 15; i >= 0; i--) begin
            serIn <= wr[i];
            #32;
            sclk <= 1'b1;
            rd[i] = serOut;
            enOk = enOk & (serOutEn === 1'b1);
            #32;
            sclk <= 1'b0;
        end
        #32;
        syncN <= 1'b1;
        // Released line must not keep its last value
        serIn <= ~serIn;
        #48;
    endtask : frame
endmodule : adcsr_host_model
`default_nettype wire

// [tb/adcsr_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module adcsr_regs_tb_top;
    import adcsr_pkg::*;
    logic clk, rst_n, sclk, syncN, serIn, serOut, serOutEn;
    logic convBusy, calDone, calUpdValid, calStartFlag;
    logic [15:0] convResult, statusWord;
    logic [3:0] calUpdIndex;
    logic [13:0] calUpdData, ctrlOut;
    logic [13:0] calExp [10];
    int failures = 0;
    int checks_done = 0;

    adcsr_regs adcsr_regs_i (.clk(clk), .rst_n(rst_n), .sclk(sclk), .syncN(syncN),
        .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn), .convBusy(convBusy),
        .convResult(convResult), .calDone(calDone), .calUpdValid(calUpdValid),
        .calUpdIndex(calUpdIndex), .calUpdData(calUpdData), .ctrlOut(ctrlOut),
        .calStartFlag(calStartFlag), .statusWord(statusWord));
    adcsr_host_model adcsr_host_model_i (.sclk(sclk), .syncN(syncN), .serIn(serIn),
        .serOut(serOut), .serOutEn(serOutEn));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
        logic enOk;
        adcsr_host_model_i.frame(wr, rd, enOk);
        chk({15'h0000, enOk}, 16'h0001);
    endtask : xfer
    task automatic ctrlWr(input logic [13:0] c);
        logic [15:0] rd;
        xfer({DEST_CTRL, c}, rd);
    endtask : ctrlWr
    task automatic rdExp(input logic [15:0] exp);
        logic [15:0] rd;
        xfer(16'h0000, rd);
        chk(rd, exp);
    endtask : rdExp
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        chk(statusWord, 16'h0000);
        chk({2'h0, ctrlOut}, 16'h0000);
        chk({15'h0000, calStartFlag}, 16'h0000);
        $display("test reset done");
    endtask : test_reset
    task automatic test_status;
        logic [15:0] rd;
        @(posedge clk) convBusy <= 1'b1;
        ctrlWr(14'h2DEC);
        rdExp(16'h6DEC);
        rdExp(16'h6DCC);
        xfer({DEST_NONE, 14'h3FFF}, rd);
        chk(statusWord, 16'h6DCC);
        @(posedge clk) convBusy <= 1'b0;
        @(posedge clk);
        #1 chk(statusWord, 16'h2DCC);
        $display("test status done");
    endtask : test_status
    task automatic test_cal_full;
        logic [15:0] rd;
        ctrlWr(14'h0080);
        for (int i = 0; i < 10; i++) begin
            calExp[i] = 14'h1234 + 14'(i * 16'h0A0B) | 14'h2000;
            xfer({DEST_CAL, calExp[i]}, rd);
        end
        @(posedge clk) begin
            calUpdValid <= 1'b1;
            calUpdIndex <= 4'h9;
            calUpdData <= 14'h3ABC;
        end
        @(posedge clk) calUpdValid <= 1'b0;
        calExp[9] = 14'h3ABC;
        ctrlWr(14'h0080);
        for (int i = 0; i < 11; i++) begin
            rdExp({2'b00, calExp[i % 10]});
        end
        $display("test cal full done");
    endtask : test_cal_full
    task automatic test_groups;
        logic [3:0] idx;
        for (int g = 1; g < 4; g++) begin
            ctrlWr(14'h0080 | 14'(g << 1));
            chk({14'h0000, statusWord[2:1]}, 16'(g));
            for (int k = 0; k < 3; k++) begin
                idx = (g == 1) ? 4'(k % 2) : (g == 2) ? 4'h1 : 4'h0;
                rdExp({2'b00, calExp[idx]});
            end
        end
        $display("test groups done");
    endtask : test_groups
    task automatic test_abort;
        ctrlWr(14'h0080);
        for (int i = 0; i < 3; i++) begin
            rdExp({2'b00, calExp[i]});
        end
        ctrlWr(14'h0080);
        rdExp({2'b00, calExp[0]});
        $display("test abort done");
    endtask : test_abort
    task automatic test_calrun;
        ctrlWr(14'h0009);
        chk({15'h0000, calStartFlag}, 16'h0001);
        chk(statusWord, 16'h4009);
        rdExp(16'h0ABC);
        @(posedge clk) calDone <= 1'b1;
        @(posedge clk) calDone <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, calStartFlag}, 16'h0000);
        chk(statusWord, 16'h0008);
        $display("test calrun done");
    endtask : test_calrun
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        convBusy = 1'b0;
        convResult = 16'h0ABC;
        calDone = 1'b0;
        calUpdValid = 1'b0;
        calUpdIndex = 4'h0;
        calUpdData = 14'h0000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1 test_reset();
        test_status();
        test_cal_full();
        test_groups();
        test_abort();
        test_calrun();
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule : adcsr_regs_tb_top
`default_nettype wire
